// >>> shared/alm_map.vh
`ifndef ALM_MAP_VH
`define ALM_MAP_VH

// ****************************************************************
// Pointer values
// ****************************************************************
`define ALM_PTR_RESULT 8'h00
`define ALM_PTR_STATUS 8'h01
`define ALM_PTR_CONFIG 8'h02
`define ALM_PTR_LOWER 8'h03
`define ALM_PTR_UPPER 8'h04
`define ALM_PTR_HYST 8'h05

// ****************************************************************
// Configuration fields
// ****************************************************************
`define ALM_CFG_INTERVAL_HI 7
`define ALM_CFG_INTERVAL_LO 5
`define ALM_CFG_HOLD 4
`define ALM_CFG_FLAG_EN 3
`define ALM_CFG_PIN_EN 2
`define ALM_CFG_POLARITY 0
`define ALM_CFG_WRITE_MASK 8'hfd

// ****************************************************************
// Status and result fields
// ****************************************************************
`define ALM_STAT_OVER 1
`define ALM_STAT_UNDER 0
`define ALM_RES_FLAG 15
`define ALM_FIELD_HI 11
`define ALM_FIELD_LO 4

// ****************************************************************
// Reset values
// ****************************************************************
`define ALM_CONFIG_RESET 8'h00
`define ALM_LOWER_RESET 16'h0000
`define ALM_UPPER_RESET 16'h0fff
`define ALM_HYST_RESET 16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define ALM_CONV_TIME_NS 1000
`define ALM_CLK_PERIOD_NS 40
`define ALM_CONV_CYCLES ((`ALM_CONV_TIME_NS + `ALM_CLK_PERIOD_NS - 1) / `ALM_CLK_PERIOD_NS)
`define ALM_INTERVAL_SHIFT 4
`define ALM_TIMER_W 24

`endif

// >>> design/alm_interval_timer.v
`timescale 1ns/1ns
`default_nettype none
`include "alm_map.vh"

module alm_interval_timer #(
   parameter [15:0] CONV_CYCLES = 16'h0019
) (
   input wire core_clk,
   input wire rst_b,
   input wire [2:0] interval_code,
   output reg tick
);

   reg [`ALM_TIMER_W-1:0] count;
   reg [2:0] last_code;
   wire [`ALM_TIMER_W-1:0] span;

   // Code n gives a spacing of the conversion time times 2^(n+4)
   // Shift amount is four bits wide, since codes above 3 would wrap in three
   assign span = {8'h00, CONV_CYCLES} << ({1'b0, interval_code} + 4'h4);

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= {`ALM_TIMER_W{1'b0}};
         last_code <= 3'b000;
         tick <= 1'b0;
      end else begin
         last_code <= interval_code;
         tick <= 1'b0;
         if (interval_code == 3'b000) begin
            count <= {`ALM_TIMER_W{1'b0}};
         end else if (interval_code != last_code) begin
            // A new code restarts the spacing with an immediate conversion
            count <= {`ALM_TIMER_W{1'b0}};
         end else if (count == {`ALM_TIMER_W{1'b0}}) begin
            tick <= 1'b1;
            count <= span - {{(`ALM_TIMER_W-1){1'b0}}, 1'b1};
         end else begin
            count <= count - {{(`ALM_TIMER_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // alm_interval_timer

`default_nettype wire

// >>> design/alm_range_flag.v
`timescale 1ns/1ns
`default_nettype none

module alm_range_flag (
   input wire core_clk,
   input wire rst_b,
   input wire sample_valid,
   input wire violate,
   input wire release_ok,
   input wire hold,
   input wire host_clear,
   output reg flag
);

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag <= 1'b0;
      end else if (sample_valid && violate) begin
         // A violation in the same cycle as a host clear keeps the flag set
         flag <= 1'b1;
      end else if (host_clear) begin
         flag <= 1'b0;
      end else if (sample_valid && release_ok && !hold) begin
         flag <= 1'b0;
      end
   end

endmodule // alm_range_flag

`default_nettype wire

// >>> design/alm_monitor.v
// Summary of operation
// - Interval code zero disables automatic conversion
// - Automatic mode off after reset
// - Nonzero interval code starts repeated conversions
// - Spacing is conversion time times 32..2048
// - Hold clear: flags self-clear past hysteresis
// - Hold set: only host write clears flags
// - Flag-enable bit gates result bit 15
// - Pin-enable bit drives pin, else released
// - Polarity bit picks pin active level
// - Variants without pin ignore pin bits
// - Reserved bits read zero, host writes zero
// - Result below lower limit raises under-range
// - Result above upper limit raises over-range
// - Pointers 02h, 03h, 04h select registers
// - Upper limit resets to 0ff0h
// - Lower limit resets to zero
// - Status bits 1/0 set, write-one clears
// - Self-clear thresholds use limit and hysteresis
// - Bit 15 high when any flag set and flag-enable bit set
`timescale 1ns/1ns
`default_nettype none
`include "alm_map.vh"

module alm_monitor #(
   parameter HAS_ALERT_PIN = 1,
   parameter [15:0] CONV_CYCLES = `ALM_CONV_CYCLES
) (
   input wire core_clk,
   input wire rst_b,
   input wire [7:0] reg_ptr,
   input wire reg_wr_en,
   input wire [15:0] reg_wr_data,
   input wire reg_rd_en,
   output reg [15:0] reg_rd_data,
   output reg conv_start,
   input wire conv_done,
   input wire [7:0] conv_data,
   output reg auto_mode,
   output reg alert_out,
   output reg alert_oe
);

   // ****************************************************************
   // Decoding
   // ****************************************************************
   function ptr_is;
      input [7:0] ptr;
      input [7:0] code;
      begin
         ptr_is = (ptr == code);
      end
   endfunction

   wire wr_status;
   wire wr_config;
   wire wr_lower;
   wire wr_upper;
   wire wr_hyst;
   wire rd_result;

   assign wr_status = reg_wr_en && ptr_is(reg_ptr, `ALM_PTR_STATUS);
   assign wr_config = reg_wr_en && ptr_is(reg_ptr, `ALM_PTR_CONFIG);
   assign wr_lower = reg_wr_en && ptr_is(reg_ptr, `ALM_PTR_LOWER);
   assign wr_upper = reg_wr_en && ptr_is(reg_ptr, `ALM_PTR_UPPER);
   assign wr_hyst = reg_wr_en && ptr_is(reg_ptr, `ALM_PTR_HYST);
   assign rd_result = reg_rd_en && ptr_is(reg_ptr, `ALM_PTR_RESULT);

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [7:0] conversion_config;
   reg [7:0] lower_threshold;
   reg [7:0] upper_threshold;
   reg [7:0] hysteresis_margin;
   reg [7:0] result;

   // Reset words kept at full width so only the stored field is taken
   localparam [15:0] lower_rst_word = `ALM_LOWER_RESET;
   localparam [15:0] upper_rst_word = `ALM_UPPER_RESET;
   localparam [15:0] hyst_rst_word = `ALM_HYST_RESET;

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         conversion_config <= `ALM_CONFIG_RESET;
      end else if (wr_config) begin
         // Bit 1 is never stored so it reads back as zero
         conversion_config <= reg_wr_data[7:0] & `ALM_CFG_WRITE_MASK;
      end
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         lower_threshold <= lower_rst_word[`ALM_FIELD_HI:`ALM_FIELD_LO];
      end else if (wr_lower) begin
         lower_threshold <= reg_wr_data[`ALM_FIELD_HI:`ALM_FIELD_LO];
      end
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         upper_threshold <= upper_rst_word[`ALM_FIELD_HI:`ALM_FIELD_LO];
      end else if (wr_upper) begin
         upper_threshold <= reg_wr_data[`ALM_FIELD_HI:`ALM_FIELD_LO];
      end
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         hysteresis_margin <= hyst_rst_word[`ALM_FIELD_HI:`ALM_FIELD_LO];
      end else if (wr_hyst) begin
         hysteresis_margin <= reg_wr_data[`ALM_FIELD_HI:`ALM_FIELD_LO];
      end
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         result <= 8'h00;
      end else if (conv_done) begin
         result <= conv_data;
      end
   end

   // ****************************************************************
   // Conversion scheduling
   // ****************************************************************
   wire [2:0] interval_code;
   wire auto_tick;
   reg conv_busy;
   reg conv_pending;
   wire want_conv;

   assign interval_code = conversion_config[`ALM_CFG_INTERVAL_HI:`ALM_CFG_INTERVAL_LO];

   alm_interval_timer #(
      .CONV_CYCLES(CONV_CYCLES)
   ) u_timer (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .interval_code(interval_code),
      .tick(auto_tick)
   );

   // A result read starts a conversion only outside automatic mode
   assign want_conv = conv_pending || auto_tick || (rd_result && interval_code == 3'b000);

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         auto_mode <= 1'b0;
      end else begin
         auto_mode <= (interval_code != 3'b000);
      end
   end

   // Requests that arrive while busy wait rather than being dropped
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_start <= 1'b0;
         conv_busy <= 1'b0;
         conv_pending <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         if (conv_busy) begin
            if (conv_done) begin
               conv_busy <= 1'b0;
            end
            if (auto_tick || (rd_result && interval_code == 3'b000)) begin
               conv_pending <= 1'b1;
            end
         end else if (want_conv) begin
            conv_start <= 1'b1;
            conv_busy <= 1'b1;
            conv_pending <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Limit comparison
   // ****************************************************************
   wire [8:0] upper_ext;
   wire [8:0] lower_ext;
   wire [8:0] sample_ext;
   wire [8:0] sample_plus_hyst;
   wire [8:0] lower_plus_hyst;
   wire [1:0] violate;
   wire [1:0] release_ok;
   wire [1:0] host_clear;
   wire [1:0] flags;

   assign upper_ext = {1'b0, upper_threshold};
   assign lower_ext = {1'b0, lower_threshold};
   assign sample_ext = {1'b0, conv_data};
   assign sample_plus_hyst = sample_ext + {1'b0, hysteresis_margin};
   assign lower_plus_hyst = lower_ext + {1'b0, hysteresis_margin};

   assign violate[`ALM_STAT_OVER] = sample_ext > upper_ext;
   assign violate[`ALM_STAT_UNDER] = sample_ext < lower_ext;
   // Sums are nine bits wide so a large margin cannot wrap around
   assign release_ok[`ALM_STAT_OVER] = sample_plus_hyst < upper_ext;
   assign release_ok[`ALM_STAT_UNDER] = sample_ext > lower_plus_hyst;
   assign host_clear[`ALM_STAT_OVER] = wr_status && reg_wr_data[`ALM_STAT_OVER];
   assign host_clear[`ALM_STAT_UNDER] = wr_status && reg_wr_data[`ALM_STAT_UNDER];

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_flag
         alm_range_flag u_flag (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .sample_valid(conv_done),
            .violate(violate[gi]),
            .release_ok(release_ok[gi]),
            .hold(conversion_config[`ALM_CFG_HOLD]),
            .host_clear(host_clear[gi]),
            .flag(flags[gi])
         );
      end
   endgenerate

   wire any_flag;
   assign any_flag = |flags;

   // ****************************************************************
   // Alert pin
   // ****************************************************************
   // The pin is released rather than driven when disabled or absent
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         alert_out <= 1'b0;
         alert_oe <= 1'b0;
      end else if (HAS_ALERT_PIN == 0) begin
         alert_out <= 1'b0;
         alert_oe <= 1'b0;
      end else begin
         alert_oe <= conversion_config[`ALM_CFG_PIN_EN];
         alert_out <= conversion_config[`ALM_CFG_POLARITY] ? any_flag : ~any_flag;
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   reg [15:0] next_rd_data;
   wire res_flag;

   assign res_flag = conversion_config[`ALM_CFG_FLAG_EN] & any_flag;

   always @* begin
      next_rd_data = 16'h0000;
      if (ptr_is(reg_ptr, `ALM_PTR_RESULT)) begin
         next_rd_data[`ALM_RES_FLAG] = res_flag;
         next_rd_data[`ALM_FIELD_HI:`ALM_FIELD_LO] = result;
      end else if (ptr_is(reg_ptr, `ALM_PTR_STATUS)) begin
         next_rd_data[1:0] = flags;
      end else if (ptr_is(reg_ptr, `ALM_PTR_CONFIG)) begin
         next_rd_data[7:0] = conversion_config;
      end else if (ptr_is(reg_ptr, `ALM_PTR_LOWER)) begin
         next_rd_data[`ALM_FIELD_HI:`ALM_FIELD_LO] = lower_threshold;
      end else if (ptr_is(reg_ptr, `ALM_PTR_UPPER)) begin
         next_rd_data[`ALM_FIELD_HI:`ALM_FIELD_LO] = upper_threshold;
      end else if (ptr_is(reg_ptr, `ALM_PTR_HYST)) begin
         next_rd_data[`ALM_FIELD_HI:`ALM_FIELD_LO] = hysteresis_margin;
      end
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rd_data <= 16'h0000;
      end else if (reg_rd_en) begin
         reg_rd_data <= next_rd_data;
      end
   end

endmodule // alm_monitor

`default_nettype wire

// >>> testbench/alm_chk_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ************
// Port checks
// ************
module alm_chk #(
   parameter [15:0] CONV_CYCLES = 16'h0019
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_ptr,
   input wire logic reg_wr_en,
   input wire logic [15:0] reg_wr_data,
   input wire logic reg_rd_en,
   input wire logic [15:0] reg_rd_data,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [7:0] conv_data,
   input wire logic auto_mode,
   input wire logic alert_out,
   input wire logic alert_oe
);
   logic [7:0] cfg;
   logic cfg_auto;
   assign cfg_auto = |cfg[7:5];
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Shadow of the config register as written by the host
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) cfg <= 8'h00;
      else if (reg_wr_en && reg_ptr == 8'h02) cfg <= reg_wr_data[7:0];
   end
   sequence s_auto_on;
      !auto_mode && reg_wr_en && reg_ptr == 8'h02 && reg_wr_data[7:5] != 3'h0;
   endsequence
   sequence s_first_start;
      ##[2:6] conv_start;
   endsequence
   a_auto_follow: assert property (auto_mode == $past(cfg_auto))
      else $error("auto mode wrong");
   a_auto_start: assert property (s_auto_on |-> s_first_start)
      else $error("no start after enable");
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("start too long");
   a_pin_released: assert property (!cfg[2] ##1 !cfg[2] |-> !alert_oe)
      else $error("pin driven");
   a_cfg_readback: assert property (reg_rd_en && reg_ptr == 8'h02 |=>
      reg_rd_data == {8'h00, $past(cfg) & 8'hfd}) else $error("config read");
   a_flag_gate: assert property (reg_rd_en && reg_ptr == 8'h00 && !cfg[3] |=>
      !reg_rd_data[15]) else $error("flag not gated");
   a_limit_fields: assert property (reg_rd_en && reg_ptr inside {8'h03, 8'h04, 8'h05} |=>
      reg_rd_data[15:12] == 4'h0 && reg_rd_data[3:0] == 4'h0) else $error("limit bits");
   a_status_bits: assert property (reg_rd_en && reg_ptr == 8'h01 |=>
      reg_rd_data[15:2] == 14'h0000) else $error("status bits");
endmodule // alm_chk

bind alm_monitor alm_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.core_clk(core_clk),
   .rst_b(rst_b), .reg_ptr(reg_ptr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
   .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .conv_start(conv_start),
   .conv_done(conv_done), .conv_data(conv_data), .auto_mode(auto_mode),
   .alert_out(alert_out), .alert_oe(alert_oe));
`default_nettype wire

// >>> testbench/alm_conv_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************
// Converter: answers a start after lat+1 cycles
// ************
module alm_conv_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic conv_start,
   input wire logic [7:0] sample,
   input wire logic [2:0] lat,
   output logic conv_done,
   output logic [7:0] conv_data
);
   int cnt;
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         conv_done <= 1'h0;
         conv_data <= 8'h00;
      end else begin
         conv_done <= 1'h0;
         // Data churns outside the done pulse so a stale value is never trusted
         conv_data <= ~conv_data;
         if (conv_start) cnt <= lat + 1;
         else if (cnt == 1) begin
            conv_done <= 1'h1;
            conv_data <= sample;
            cnt <= 0;
         end else if (cnt > 1) cnt <= cnt - 1;
      end
   end
endmodule // alm_conv_model
`default_nettype wire

// >>> testbench/adc_limit_monitor_config_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module adc_limit_monitor_config_tb_top;
   localparam CC = 2;
   logic core_clk = 1'h0;
   logic rst_b = 1'h0;
   logic [7:0] reg_ptr = 8'h00;
   logic reg_wr_en = 1'h0;
   logic reg_rd_en = 1'h0;
   logic [15:0] reg_wr_data = 16'h0000;
   logic [15:0] reg_rd_data;
   logic conv_start, conv_done, auto_mode, alert_out, alert_oe;
   logic [7:0] conv_data;
   logic [7:0] sample = 8'h80;
   logic [2:0] lat = 3'h0;
   logic [7:0] cfg = 8'h00, lower = 8'h00, upper = 8'hff, hyst = 8'h00, res = 8'h00;
   logic ov = 1'h0, un = 1'h0;
   logic [31:0] seed = 32'h8436fba8;
   int err_count = 0, n_tests = 0;
   int sc[$] = '{'h340, 'h4c0, 'h510, 'h20d, 'h0c0, 'h0d0, 'h0b5, 'h0af, 'h040, 'h030,
      'h050, 'h051, 'h21c, 'h0d0, 'h080, 'h102, 'h030, 'h102, 'h101, 'h200, 'h0d0, 'h0c1};
   always #20 core_clk = ~core_clk;
   alm_monitor #(.HAS_ALERT_PIN(1), .CONV_CYCLES(16'h0002)) u_dut (.core_clk(core_clk),
      .rst_b(rst_b), .reg_ptr(reg_ptr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
      .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .conv_start(conv_start),
      .conv_done(conv_done), .conv_data(conv_data), .auto_mode(auto_mode),
      .alert_out(alert_out), .alert_oe(alert_oe));
   alm_conv_model u_conv (.core_clk(core_clk), .rst_b(rst_b), .conv_start(conv_start),
      .sample(sample), .lat(lat), .conv_done(conv_done), .conv_data(conv_data));
   // ************
   // Reference flags, updated on every finished conversion
   // ************
   always @(posedge core_clk) begin
      if (rst_b && conv_done) begin
         res = conv_data;
         if (res > upper) ov = 1'h1;
         else if (!cfg[4] && 9'h000 + res + hyst < upper) ov = 1'h0;
         if (res < lower) un = 1'h1;
         else if (!cfg[4] && res > 9'h000 + lower + hyst) un = 1'h0;
      end
   end
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task ck(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'h1) begin
         err_count++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task final_report;
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task drain;
      repeat (12) @(negedge core_clk);
   endtask
   task wr(input logic [7:0] p, input logic [15:0] d);
      reg_ptr = p;
      reg_wr_en = 1'h1;
      reg_wr_data = d;
      @(negedge core_clk);
      reg_wr_en = 1'h0;
      case (p)
         8'h01: {ov, un} = {ov, un} & ~d[1:0];
         8'h02: cfg = d[7:0] & 8'hfd;
         8'h03: lower = d[11:4];
         8'h04: upper = d[11:4];
         8'h05: hyst = d[11:4];
         default: ;
      endcase
      // One idle edge so the next call never raises a strobe in this time step
      @(negedge core_clk);
   endtask
   task rd(input logic [7:0] p);
      logic [15:0] e;
      case (p)
         8'h00: e = {cfg[3] & (ov | un), 3'h0, res, 4'h0};
         8'h01: e = {14'h0000, ov, un};
         8'h02: e = {8'h00, cfg};
         8'h03: e = {4'h0, lower, 4'h0};
         8'h04: e = {4'h0, upper, 4'h0};
         8'h05: e = {4'h0, hyst, 4'h0};
         default: e = 16'h0000;
      endcase
      reg_ptr = p;
      reg_rd_en = 1'h1;
      @(negedge core_clk);
      reg_rd_en = 1'h0;
      ck(reg_rd_data === e, "read data");
      @(negedge core_clk);
   endtask
   task pin;
      ck(alert_oe === cfg[2] && alert_out === ~(cfg[0] ^ (ov | un)), "alert pin");
   endtask
   task conv(input logic [7:0] s);
      int n;
      n = xs();
      lat = n[2:0];
      sample = s;
      rd(8'h00);
      n = 0;
      while (conv_done !== 1'h1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      ck(n < 40, "no conversion");
   endtask
   task gap(input logic [2:0] c);
      int n, r;
      wr(8'h02, {8'h00, c, 5'h0d});
      for (int k = 0; k < 3; k++) begin
         n = 0;
         r = xs();
         sample = r[7:0];
         do begin
            @(negedge core_clk);
            n++;
         end while (conv_start !== 1'h1 && n < 9000);
      end
      ck(n == (CC << (c + 4)), "auto spacing");
      rd(8'h01);
      wr(8'h02, 16'h0000);
      drain;
      pin();
   endtask
   initial begin
      int n;
      repeat (16) @(negedge core_clk);
      rst_b = 1'h1;
      for (int p = 0; p < 8; p++) rd(p[7:0]);
      pin();
      wr(8'h00, 16'hffff);
      wr(8'h07, 16'hffff);
      wr(8'h02, 16'hff1f);
      wr(8'h03, 16'hf00f);
      wr(8'h04, 16'hffff);
      drain;
      for (int p = 0; p < 8; p++) rd(p[7:0]);
      foreach (sc[i]) begin
         if (sc[i][11:8] == 4'h0) conv(sc[i][7:0]);
         else if (sc[i][11:8] < 4'h3) wr({4'h0, sc[i][11:8]}, {8'h00, sc[i][7:0]});
         else wr({4'h0, sc[i][11:8]}, {4'h0, sc[i][7:0], 4'h0});
         drain;
         rd(8'h01);
         pin();
         rd(8'h00);
         drain;
      end
      n = xs();
      wr(8'h03, {4'h0, n[7:0], 4'h0});
      wr(8'h04, {4'h0, n[15:8], 4'h0});
      for (int c = 1; c < 8; c++) gap(c[2:0]);
      rd(8'h00);
      final_report;
   end
   initial begin
      #(40 * 40000);
      err_count++;
      final_report;
   end
endmodule // adc_limit_monitor_config_tb_top
`default_nettype wire
